// ==== cic_pkg.sv ====
package cic_pkg;

  // system clock rate and configuration shift clock timing
  localparam int unsigned SYS_CLK_MHZ  = 125;
  localparam int unsigned CFG_HALF_NS  = 40;
  // least time, so round up to whole cycles
  localparam int unsigned CFG_HALF_CYC = (CFG_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W        = 4;

  // management register map
  localparam int unsigned ADDR_W                   = 8;
  localparam int unsigned DATA_W                   = 16;
  localparam int unsigned CAP_W                    = 8;
  localparam logic [7:0]  REG_BOARD_CONFIG_CAPTURE = 8'hAC;
  localparam logic [7:0]  REG_REPEATER_CONFIG      = 8'h88;
  localparam int unsigned CFG_MODE_BIT             = 14;
  localparam logic [15:0] REPEATER_CONFIG_RST      = 16'h0000;
  localparam logic [7:0]  CAPTURE_RST              = 8'h00;
  localparam logic [7:0]  CAPTURE_PAD              = 8'h00;
  localparam logic [15:0] READ_ZERO                = 16'h0000;

  // serial capture
  localparam logic [3:0]  CFG_BITS     = 4'h8;
  localparam logic [1:0]  PRIMARY_ID   = 2'h0;
  localparam int unsigned TRACK_W      = 16;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_LOAD,
    SEQ_SETTLE,
    SEQ_HIGH,
    SEQ_LOW
  } cic_seq_e;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cic_mgmt_req_s;

  typedef struct packed {
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
  } cic_mgmt_rsp_s;

  typedef struct packed {
    cic_seq_e         seq;
    logic [CNT_W-1:0] timer;
    logic [3:0]       bitcnt;
    logic             serial_run;
    logic [CAP_W-1:0] shreg;
    logic [CAP_W-1:0] capture;
    logic [CAP_W-1:0] pub_data;
    logic             req_tgl;
    logic             rd_prev;
    logic             load_n;
    logic             load_oe;
    logic             shift_clk;
    logic             irq_drive;
    logic [1:0]       pos_id;
    logic             primary;
  } cic_sys_state_s;

  typedef struct packed {
    logic [DATA_W-1:0] repcfg;
    logic              rd_tgl;
    logic [CAP_W-1:0]  shadow;
    logic              ack_tgl;
    cic_mgmt_rsp_s     rsp;
  } cic_link_state_s;

  localparam cic_sys_state_s SYS_STATE_RST = '{
    seq:        SEQ_IDLE,
    timer:      '0,
    bitcnt:     '0,
    serial_run: 1'b0,
    shreg:      CAPTURE_RST,
    capture:    CAPTURE_RST,
    pub_data:   CAPTURE_RST,
    req_tgl:    1'b0,
    rd_prev:    1'b0,
    load_n:     1'b1,
    load_oe:    1'b0,
    shift_clk:  1'b0,
    irq_drive:  1'b0,
    pos_id:     PRIMARY_ID,
    primary:    1'b0
  };

  localparam cic_link_state_s LINK_STATE_RST = '{
    repcfg:  REPEATER_CONFIG_RST,
    rd_tgl:  1'b0,
    shadow:  CAPTURE_RST,
    ack_tgl: 1'b0,
    rsp:     '{rvalid: 1'b0, rdata: READ_ZERO}
  };

endpackage : cic_pkg

// ==== cic_sync2.sv ====
module cic_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : cic_sync2

// ==== cic_config_input_capture.sv ====
// Operation
// - reset low clears circuits, machines, counters
// - address tracking storage survives reset untouched
// - runs from a system clock plus a separate management link clock
// - two position id pins identify device
// - direct mode mirrors two pins into 0xAC
// - repeater config bit 14 selects capture mode
// - serial mode gathers eight bits from shifter
// - serial mode drives active-low load strobe
// - a capture register read while idle pulses shift clock
// - shift clock pin doubles as led clock
// - interrupt is active-low open-drain output
module cic_config_input_capture #(
  parameter int unsigned HALF_CYCLES = cic_pkg::CFG_HALF_CYC
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   clk_link_i,
  input  wire cic_pkg::cic_mgmt_req_s mgmt_req_i,
  output cic_pkg::cic_mgmt_rsp_s      mgmt_rsp_o,
  input  wire logic                   config0_data_i,
  input  wire logic                   config1_load_i,
  output logic                        setting_bus_load_n_o,
  output logic                        setting_bus_load_n_oe_o,
  input  wire logic [1:0]             board_position_id_i,
  output logic [1:0]                  board_position_id_o,
  output logic                        position_primary_o,
  input  wire logic                   led_shift_clock_req_i,
  output logic                        led_shift_clock_o,
  input  wire logic                   irq_req_i,
  output logic                        irq_n_o,
  output logic                        irq_n_oe_o,
  input  wire logic                   track_load_i,
  input  wire logic [15:0]            track_addr_i,
  output logic [15:0]                 track_addr_o,
  output logic [7:0]                  capture_o,
  output logic                        capture_busy_o
);

  import cic_pkg::*;

  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);

  function automatic logic timer_done(input logic [CNT_W-1:0] t);
    timer_done = (t == HALF_LAST);
  endfunction : timer_done

  function automatic logic is_addr(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] reg_addr);
    is_addr = (a == reg_addr);
  endfunction : is_addr

  cic_sys_state_s  s;
  cic_sys_state_s  next_s;
  cic_link_state_s l;
  cic_link_state_s next_l;

  logic [TRACK_W-1:0] track;

  // system domain synchronised inputs
  logic [6:0] sys_async;
  logic [6:0] sys_sync;
  logic       setting_bus_serial_in;
  logic       cfg1_pin;
  logic [1:0] pos_sync;
  logic       rd_sync;
  logic       ack_sync;
  logic       mode_serial;
  logic       start;
  logic       pub_idle;

  // link domain synchronised input
  logic       req_sync;

  assign sys_async = {l.repcfg[CFG_MODE_BIT],
                      l.ack_tgl,
                      l.rd_tgl,
                      board_position_id_i,
                      config1_load_i,
                      config0_data_i};

  // pins and link-domain toggles both pass two flops before use
  cic_sync2 #(
    .W (7)
  ) u_sys_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     (sys_async),
    .q_o     (sys_sync)
  );

  cic_sync2 #(
    .W (1)
  ) u_link_sync (
    .clk_i   (clk_link_i),
    .rst_n_i (rst_n_i),
    .d_i     (s.req_tgl),
    .q_o     (req_sync)
  );

  assign setting_bus_serial_in      = sys_sync[0];
  assign cfg1_pin    = sys_sync[1];
  assign pos_sync    = sys_sync[3:2];
  assign rd_sync     = sys_sync[4];
  assign ack_sync    = sys_sync[5];
  assign mode_serial = sys_sync[6];

  // a read of the capture register arrives as a toggle edge
  assign start    = rd_sync ^ s.rd_prev;
  assign pub_idle = (ack_sync == s.req_tgl);

  // system domain: capture sequencer and pin drivers
  always_comb begin
    next_s = s;
    next_s.rd_prev = rd_sync;
    next_s.pos_id  = pos_sync;
    // only one strapped device may source shared resources
    next_s.primary   = (pos_sync == PRIMARY_ID);
    next_s.irq_drive = irq_req_i;

    // word crossing: publish only once the previous word was acknowledged
    if (pub_idle && (s.pub_data != s.capture)) begin
      next_s.pub_data = s.capture;
      next_s.req_tgl  = ~s.req_tgl;
    end

    unique case (s.seq)
      SEQ_IDLE: begin
        if (!mode_serial) begin
          next_s.capture = {CAPTURE_PAD[CAP_W-1:2], cfg1_pin, cfg0_data_sync()};
        end
        // reads during a running sequence are absorbed by that sequence
        if (start) begin
          next_s.timer = '0;
          if (mode_serial) begin
            next_s.seq        = SEQ_LOAD;
            next_s.bitcnt     = '0;
            next_s.serial_run = 1'b1;
          end else begin
            next_s.seq        = SEQ_HIGH;
            next_s.bitcnt     = CFG_BITS;
            next_s.serial_run = 1'b0;
          end
        end
      end
      SEQ_LOAD: begin
        next_s.timer = s.timer + 1'b1;
        if (timer_done(s.timer)) begin
          next_s.seq   = SEQ_SETTLE;
          next_s.timer = '0;
        end
      end
      SEQ_SETTLE, SEQ_LOW: begin
        next_s.timer = s.timer + 1'b1;
        if (timer_done(s.timer)) begin
          // sample ahead of the rising edge that shifts the next bit out
          next_s.shreg  = {s.shreg[CAP_W-2:0], setting_bus_serial_in};
          next_s.bitcnt = s.bitcnt + 1'b1;
          next_s.seq    = SEQ_HIGH;
          next_s.timer  = '0;
        end
      end
      SEQ_HIGH: begin
        next_s.timer = s.timer + 1'b1;
        if (timer_done(s.timer)) begin
          next_s.timer = '0;
          if (s.bitcnt == CFG_BITS) begin
            next_s.seq = SEQ_IDLE;
            if (s.serial_run) begin
              next_s.capture = s.shreg;
            end
            next_s.serial_run = 1'b0;
          end else begin
            next_s.seq = SEQ_LOW;
          end
        end
      end
    endcase

    // load pin is an input in direct mode and our strobe in serial mode
    next_s.load_oe   = mode_serial;
    next_s.load_n    = (next_s.seq != SEQ_LOAD);
    // led stream owns the pin only while no capture sequence runs
    next_s.shift_clk = (next_s.seq == SEQ_HIGH) ||
                       ((next_s.seq == SEQ_IDLE) && led_shift_clock_req_i);
  end

  function automatic logic cfg0_data_sync();
    cfg0_data_sync = setting_bus_serial_in;
  endfunction : cfg0_data_sync

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= SYS_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // tracking storage has no reset so its contents live through it
  always_ff @(posedge clk_sys_i) begin
    if (track_load_i) begin
      track <= track_addr_i;
    end
  end

  // link domain: management register file
  always_comb begin
    next_l = l;
    next_l.rsp.rvalid = 1'b0;

    // copy the published word; sys holds it stable until our ack returns
    if (req_sync != l.ack_tgl) begin
      next_l.shadow  = s.pub_data;
      next_l.ack_tgl = req_sync;
    end

    if (mgmt_req_i.wr && is_addr(mgmt_req_i.addr, REG_REPEATER_CONFIG)) begin
      next_l.repcfg = mgmt_req_i.wdata;
    end

    if (mgmt_req_i.rd) begin
      next_l.rsp.rvalid = 1'b1;
      if (is_addr(mgmt_req_i.addr, REG_BOARD_CONFIG_CAPTURE)) begin
        next_l.rsp.rdata = {CAPTURE_PAD, l.shadow};
        next_l.rd_tgl    = ~l.rd_tgl;
      end else if (is_addr(mgmt_req_i.addr, REG_REPEATER_CONFIG)) begin
        next_l.rsp.rdata = l.repcfg;
      end else begin
        next_l.rsp.rdata = READ_ZERO;
      end
    end
  end

  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l <= LINK_STATE_RST;
    end else begin
      l <= next_l;
    end
  end

  assign mgmt_rsp_o              = l.rsp;
  assign setting_bus_load_n_o    = s.load_n;
  assign setting_bus_load_n_oe_o = s.load_oe;
  assign board_position_id_o     = s.pos_id;
  assign position_primary_o      = s.primary;
  assign led_shift_clock_o       = s.shift_clk;
  // open drain: only ever pull low, the board supplies the pull-up
  assign irq_n_o                 = 1'b0;
  assign irq_n_oe_o              = s.irq_drive;
  assign track_addr_o            = track;
  assign capture_o               = s.capture;
  assign capture_busy_o          = (s.seq != SEQ_IDLE);

endmodule : cic_config_input_capture

// ==== cic_config_input_capture_sva.sv ====
module cic_config_input_capture_sva
  import cic_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 5
) (
  input wire logic          clk_sys_i,
  input wire logic          rst_n_i,
  input wire logic          clk_link_i,
  input wire cic_mgmt_req_s mgmt_req_i,
  input wire cic_mgmt_rsp_s mgmt_rsp_o,
  input wire logic          setting_bus_load_n_o,
  input wire logic          setting_bus_load_n_oe_o,
  input wire logic [1:0]    board_position_id_o,
  input wire logic [1:0]    board_position_id_i,
  input wire logic          position_primary_o,
  input wire logic          led_shift_clock_o,
  input wire logic          irq_req_i,
  input wire logic          irq_n_o,
  input wire logic          irq_n_oe_o,
  input wire logic          track_load_i,
  input wire logic [15:0]   track_addr_o,
  input wire logic          capture_busy_o
);
  logic [4:0] lo_cnt;
  logic [4:0] hi_cnt;
  // run lengths of strobe low and clock high, checked when the run ends
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_cnt <= 5'h00;
      hi_cnt <= 5'h00;
    end else begin
      lo_cnt <= setting_bus_load_n_o ? 5'h00 : lo_cnt + 5'h01;
      hi_cnt <= led_shift_clock_o ? hi_cnt + 5'h01 : 5'h00;
    end
  end
  property p_rst_idle;
    @(posedge clk_sys_i) !rst_n_i |-> setting_bus_load_n_o && !setting_bus_load_n_oe_o
      && !capture_busy_o && !irq_n_oe_o;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
  // no disable: storage must hold across reset too
  // storage is unknown until its first load, so only watch it after that
  logic trk_seen = 1'b0;
  always_ff @(posedge clk_sys_i) begin
    if (track_load_i) begin
      trk_seen <= 1'b1;
    end
  end
  property p_track;
    @(posedge clk_sys_i) trk_seen && !$past(track_load_i) |-> $stable(track_addr_o);
  endproperty
  a_track: assert property (p_track) else $error("tracking value moved");
  property p_irq;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> irq_n_oe_o == $past(irq_req_i) && !irq_n_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq drive wrong");
  property p_primary;
    @(posedge clk_sys_i) disable iff (!rst_n_i) $past(rst_n_i, 3)
      |-> board_position_id_o == $past(board_position_id_i, 3)
      && position_primary_o == ($past(board_position_id_i, 3) == PRIMARY_ID);
  endproperty
  a_primary: assert property (p_primary) else $error("primary flag wrong");
  property p_load_len;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(setting_bus_load_n_o) |-> lo_cnt == 5'(HALF_CYCLES);
  endproperty
  a_load_len: assert property (p_load_len) else $error("load strobe length");
  property p_load_oe;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !setting_bus_load_n_o |-> setting_bus_load_n_oe_o;
  endproperty
  a_load_oe: assert property (p_load_oe) else $error("strobe low while undriven");
  property p_pulse;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(led_shift_clock_o) && $past(capture_busy_o) |-> hi_cnt == 5'(HALF_CYCLES);
  endproperty
  a_pulse: assert property (p_pulse) else $error("shift pulse length");
  property p_start;
    @(posedge clk_sys_i) disable iff (!rst_n_i) $rose(capture_busy_o) && setting_bus_load_n_oe_o
      |-> !setting_bus_load_n_o && !led_shift_clock_o;
  endproperty
  a_start: assert property (p_start) else $error("no load before shift");
  property p_rvalid;
    @(posedge clk_link_i) disable iff (!rst_n_i) mgmt_rsp_o.rvalid == $past(mgmt_req_i.rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer timing");
  c_serial: cover property (@(posedge clk_sys_i) $rose(setting_bus_load_n_o));
  c_read: cover property (@(posedge clk_link_i) mgmt_rsp_o.rvalid);
  c_primary: cover property (@(posedge clk_sys_i) $rose(position_primary_o));
endmodule : cic_config_input_capture_sva

bind cic_config_input_capture cic_config_input_capture_sva #(
  .HALF_CYCLES (HALF_CYCLES)
) u_sva (
  .clk_sys_i               (clk_sys_i),
  .rst_n_i                 (rst_n_i),
  .clk_link_i              (clk_link_i),
  .mgmt_req_i              (mgmt_req_i),
  .mgmt_rsp_o              (mgmt_rsp_o),
  .setting_bus_load_n_o    (setting_bus_load_n_o),
  .setting_bus_load_n_oe_o (setting_bus_load_n_oe_o),
  .board_position_id_o     (board_position_id_o),
  .board_position_id_i     (board_position_id_i),
  .position_primary_o      (position_primary_o),
  .led_shift_clock_o       (led_shift_clock_o),
  .irq_req_i               (irq_req_i),
  .irq_n_o                 (irq_n_o),
  .irq_n_oe_o              (irq_n_oe_o),
  .track_load_i            (track_load_i),
  .track_addr_o            (track_addr_o),
  .capture_busy_o          (capture_busy_o)
);

// ==== cic_shifter_model.sv ====
module cic_shifter_model (
  input  wire logic       load_n_i,
  input  wire logic       sclk_i,
  input  wire logic [7:0] par_i,
  output logic            data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sreg = 8'h00;
  // fills with inverted bits, so extra pulses show up as wrong data
  always @(posedge sclk_i or negedge load_n_i) begin
    if (!load_n_i) begin
      sreg <= par_i;
    end else begin
      sreg <= {sreg[6:0], ~sreg[0]};
    end
  end
  assign data_o = sreg[7];
endmodule : cic_shifter_model

// ==== tb_config_input_capture.sv ====
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_config_input_capture;
  timeunit 1ns;
  timeprecision 100ps;
  import cic_pkg::*;
  localparam int unsigned HC = 3;
  logic clk_sys_i = 1'b0, clk_link_i = 1'b0, rst_n_i = 1'b1;
  logic pin0 = 1'b0, pin1 = 1'b0, led_req = 1'b0, irq_req = 1'b0, trk_ld = 1'b0;
  logic ld_n, ld_oe, sdata, led_clk, irq_n, irq_oe, prim, busy;
  logic [1:0] id = 2'h0, id_o;
  logic [15:0] trk = 16'h0000, trk_o, rd_val;
  logic [7:0] par = 8'h00, cap;
  cic_mgmt_req_s req = '0;
  cic_mgmt_rsp_s rsp;
  int error_cnt = 0, checks = 0;
  wire cfg1 = ld_oe ? ld_n : pin1;
  wire cfg0 = ld_oe ? sdata : pin0;
  wire irq_line = irq_oe ? irq_n : 1'b1; // board pull-up
  always #4 clk_sys_i = ~clk_sys_i;
  always #3 clk_link_i = ~clk_link_i;
  cic_config_input_capture #(.HALF_CYCLES(HC)) DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i),
    .mgmt_req_i(req), .mgmt_rsp_o(rsp), .config0_data_i(cfg0), .config1_load_i(cfg1),
    .setting_bus_load_n_o(ld_n), .setting_bus_load_n_oe_o(ld_oe),
    .board_position_id_i(id), .board_position_id_o(id_o), .position_primary_o(prim),
    .led_shift_clock_req_i(led_req), .led_shift_clock_o(led_clk), .irq_req_i(irq_req),
    .irq_n_o(irq_n), .irq_n_oe_o(irq_oe), .track_load_i(trk_ld), .track_addr_i(trk),
    .track_addr_o(trk_o), .capture_o(cap), .capture_busy_o(busy));
  cic_shifter_model u_shifter (.load_n_i(cfg1), .sclk_i(led_clk), .par_i(par), .data_o(sdata));
  task stop_test;
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  // one-cycle request; answer taken one link cycle after the request edge
  task mgmt(input logic r, input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_link_i);
    #1 req = '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clk_link_i);
    #1 req = '0;
    rd_val = rsp.rdata;
  endtask : mgmt
  task idle_wait;
    int n;
    tick(12);
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clk_sys_i);
    tick(12);
    `CHK("busy end", 1'b0, busy)
  endtask : idle_wait
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial begin
    int i;
    // a real falling edge, so the asynchronous resets fire before the first clock
    #1 rst_n_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #2 rst_n_i = 1'b1;
    tick(4);
    `CHK("load_n", 1'b1, ld_n)
    `CHK("load_oe", 1'b0, ld_oe)
    mgmt(1'b1, 1'b0, REG_REPEATER_CONFIG, 16'h0000);
    `CHK("repcfg", REPEATER_CONFIG_RST, rd_val)
    mgmt(1'b0, 1'b1, REG_BOARD_CONFIG_CAPTURE, 16'hFFFF);
    mgmt(1'b1, 1'b0, 8'h55, 16'h0000);
    `CHK("unmapped", READ_ZERO, rd_val)
    pin1 = 1'b1;
    tick(8);
    `CHK("direct cap", 8'h02, cap)
    mgmt(1'b1, 1'b0, REG_BOARD_CONFIG_CAPTURE, 16'h0000);
    idle_wait();
    mgmt(1'b1, 1'b0, REG_BOARD_CONFIG_CAPTURE, 16'h0000);
    `CHK("direct read", 16'h0002, rd_val)
    for (i = 0; i < 4; i++) begin
      id = 2'(i);
      tick(5);
      `CHK("pos id", 2'(i), id_o)
      `CHK("primary", (i == 0), prim)
    end
    irq_req = 1'b1;
    tick(2);
    `CHK("irq low", 1'b0, irq_line)
    irq_req = 1'b0;
    tick(2);
    `CHK("irq high", 1'b1, irq_line)
    led_req = 1'b1;
    tick(3);
    `CHK("led clk", 1'b1, led_clk)
    led_req = 1'b0;
    tick(3);
    mgmt(1'b0, 1'b1, REG_REPEATER_CONFIG, 16'h4000);
    tick(6);
    `CHK("serial oe", 1'b1, ld_oe)
    mgmt(1'b1, 1'b0, REG_REPEATER_CONFIG, 16'h0000);
    `CHK("repcfg", 16'h4000, rd_val)
    par = 8'hB4;
    mgmt(1'b1, 1'b0, REG_BOARD_CONFIG_CAPTURE, 16'h0000);
    idle_wait();
    `CHK("serial cap", 8'hB4, cap)
    par = 8'h4B;
    mgmt(1'b1, 1'b0, REG_BOARD_CONFIG_CAPTURE, 16'h0000);
    `CHK("serial read", 16'h00B4, rd_val)
    // read while busy must not queue a second sequence
    mgmt(1'b1, 1'b0, REG_BOARD_CONFIG_CAPTURE, 16'h0000);
    tick(20);
    par = 8'hFF;
    idle_wait();
    `CHK("absorbed", 8'h4B, cap)
    mgmt(1'b1, 1'b0, REG_BOARD_CONFIG_CAPTURE, 16'h0000);
    `CHK("serial read", 16'h004B, rd_val)
    trk = 16'hC35A;
    trk_ld = 1'b1;
    tick(1);
    trk_ld = 1'b0;
    tick(4);
    #1 rst_n_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #2 rst_n_i = 1'b1;
    tick(4);
    `CHK("track kept", 16'hC35A, trk_o)
    `CHK("oe reset", 1'b0, ld_oe)
    mgmt(1'b1, 1'b0, REG_REPEATER_CONFIG, 16'h0000);
    `CHK("repcfg rst", REPEATER_CONFIG_RST, rd_val)
    stop_test();
  end
endmodule : tb_config_input_capture
